// ==== rsch_echo.sv ====
// Purpose: Serial character loopback with deferred switch-off
// Assumes: Received characters arrive as one-cycle strobes
// Notes:   Echo keeps running until the line terminator after OFF
module rsch_echo
  import rsch_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       set_valid,
  input  wire logic       set_on,
  // Receive stream
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_char,
  // Echo stream
  output logic            echo_valid,
  output logic [7:0]      echo_char,
  output logic            echo_active
);

  logic on_q;       // Echo live
  logic stop_q;     // Off requested, awaiting terminator

  always_ff @(posedge core_clk) begin
    if (reset) begin
      on_q   <= 1'b0;
      stop_q <= 1'b0;
    end else if (set_valid) begin
      on_q   <= set_on ? 1'b1 : on_q;
      stop_q <= !set_on && on_q;
    end else if (rx_valid && stop_q && rx_char == CHAR_LF) begin
      on_q   <= 1'b0;
      stop_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      echo_valid <= 1'b0;
      echo_char  <= 8'h00;
    end else begin
      echo_valid <= rx_valid && on_q;
      echo_char  <= rx_valid ? rx_char : echo_char;
    end
  end

  assign echo_active = on_q && !stop_q;

endmodule : rsch_echo

// ==== rsch_err_fifo.sv ====
// Purpose: Error queue keeping oldest entries, overflow marker last
// Assumes: Single clock, synchronous reset
// Notes:   Last slot is reserved for the overflow code
module rsch_err_fifo
  import rsch_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Push side
  input  wire logic               push,
  input  wire logic signed [15:0] push_code,
  // Pop and peek side
  input  wire logic               pop,
  input  wire logic [4:0]         peek_idx,
  output logic signed [15:0]      peek_code,
  output logic signed [15:0]      head_code,
  output logic [5:0]              count
);

  initial begin
    if (DEPTH < 2 || DEPTH > 31) begin
      $error("rsch_err_fifo: DEPTH out of range");
    end
  end

  logic signed [15:0] mem_q [DEPTH];   // Storage
  logic [4:0]         rd_q;            // Oldest entry
  logic [5:0]         cnt_q;           // Entries held
  logic               ovf_q;           // Overflow entry stored

  // Index wrap helper
  function automatic logic [4:0] wrap(input logic [5:0] i);
    wrap = (i >= 6'(DEPTH)) ? 5'(i - 6'(DEPTH)) : i[4:0];
  endfunction : wrap

  logic       do_pop;
  logic       room;
  logic [4:0] wr_idx;
  assign do_pop = pop && (cnt_q != 6'h00);
  // One free slot kept back for the overflow entry
  assign room   = (cnt_q < 6'(DEPTH - 1)) && !ovf_q;
  assign wr_idx = wrap(6'(rd_q) + cnt_q);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_q  <= 5'h00;
      cnt_q <= 6'h00;
      ovf_q <= 1'b0;
    end else begin
      if (push && room) begin
        mem_q[wr_idx] <= push_code;
      end else if (push && !ovf_q) begin
        mem_q[wr_idx] <= ERR_OVERFLOW;
        ovf_q         <= 1'b1;
      end
      if (do_pop) begin
        rd_q <= wrap(6'(rd_q) + 6'h01);
      end
      // Count follows push and pop together
      cnt_q <= cnt_q + 6'((push && !ovf_q) ? 1 : 0) - 6'(do_pop ? 1 : 0);
      // Overflow clears once its entry is read out
      if (do_pop && cnt_q == 6'h01) begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign head_code = (cnt_q == 6'h00) ? ERR_NONE : mem_q[rd_q];
  assign peek_code = mem_q[wrap(6'(rd_q) + 6'(peek_idx))];
  assign count     = cnt_q;

endmodule : rsch_err_fifo

// ==== rsch_host_model.sv ====
// Purpose: Serial host at the far side: sends characters, logs replies
// Assumes: One character per strobe
// Notes:   Idle data line shows the inverse of the last character
module rsch_host_model (
  // Clock
  input  wire logic       core_clk,
  // Transmit stream from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  // Receive stream into the device
  output logic            rx_valid,
  output logic [7:0]      rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  int         tx_cnt = 0;    // Characters heard back
  logic [7:0] last_tx = 8'h00; // Most recent character heard

  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end

  // Log every character the device sends
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1) begin
      tx_cnt  <= tx_cnt + 1;
      last_tx <= tx_char;
    end
  end

  // One character, then release the line
  task automatic send_char(input logic [7:0] ch);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_char  = ch;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_char  = ~ch;
  endtask : send_char
endmodule : rsch_host_model

// ==== rsch_pkg.sv ====
// Purpose: Shared constants for the remote system command handler
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Command opcodes, reply codes, error queue sizes, baud encodings
package rsch_pkg;

  // Command opcodes on cmd_op
  localparam logic [3:0] OP_ADDR_SET   = 4'h1;  // Set bus address
  localparam logic [3:0] OP_ADDR_QRY   = 4'h2;  // Query bus address
  localparam logic [3:0] OP_BAUD_SET   = 4'h3;  // Set serial rate
  localparam logic [3:0] OP_BAUD_QRY   = 4'h4;  // Query serial rate
  localparam logic [3:0] OP_ECHO_SET   = 4'h5;  // Echo on/off
  localparam logic [3:0] OP_ECHO_QRY   = 4'h6;  // Echo query
  localparam logic [3:0] OP_PACE_SET   = 4'h7;  // Flow control on/off
  localparam logic [3:0] OP_PACE_QRY   = 4'h8;  // Flow control query
  localparam logic [3:0] OP_PROM_SET   = 4'h9;  // Parse marker on/off
  localparam logic [3:0] OP_PROM_QRY   = 4'ha;  // Parse marker query
  localparam logic [3:0] OP_ERR_QRY    = 4'hb;  // Pop error with text
  localparam logic [3:0] OP_ERR_CODE   = 4'hc;  // Pop error, code only
  localparam logic [3:0] OP_ERR_ALL    = 4'hd;  // List every code
  localparam logic [3:0] OP_KEYB_SET   = 4'he;  // Keypad lock/unlock
  localparam logic [3:0] OP_BEEP       = 4'hf;  // One short tone
  localparam logic [3:0] OP_QMASK_QRY  = 4'h0;  // Questionable mask query

  // Baud selections, arg low bits
  localparam logic [2:0] BAUD_OFF      = 3'h0;
  localparam logic [2:0] BAUD_2400     = 3'h1;
  localparam logic [2:0] BAUD_4800     = 3'h2;
  localparam logic [2:0] BAUD_9600     = 3'h3;
  localparam logic [2:0] BAUD_19200    = 3'h4;
  localparam logic [2:0] BAUD_RESET    = BAUD_9600;

  // Bus address limits
  localparam logic [4:0] ADDR_MAX      = 5'h1e;
  localparam logic [4:0] ADDR_RESET    = 5'h06;

  // Error queue
  localparam int         ERR_DEPTH     = 31;
  localparam logic signed [15:0] ERR_OVERFLOW = -16'sd350;
  localparam logic signed [15:0] ERR_NONE     = 16'sh0000;

  // Reply kinds on rsp_kind
  localparam logic [1:0] RSP_VALUE     = 2'h0;  // Plain integer
  localparam logic [1:0] RSP_ERR_TEXT  = 2'h1;  // Code plus message
  localparam logic [1:0] RSP_ERR_CODE  = 2'h2;  // Code only
  localparam logic [1:0] RSP_LIST_END  = 2'h3;  // Last word of a list

  // Characters
  localparam logic [7:0] CHAR_PROMPT   = 8'h3e;  // '>'
  localparam logic [7:0] CHAR_LF       = 8'h0a;  // Line terminator

  // Beep length
  localparam int         BEEP_NS       = 100000;
  localparam int         CLK_NS        = 10;
  localparam int         BEEP_CYC      = BEEP_NS / CLK_NS;

endpackage : rsch_pkg

// ==== rsch_tb_top.sv ====
// Purpose: Self-checking bench for the remote command handler
// Assumes: Inputs change on the falling edge
// Notes:   Tone shortened to five cycles
module rsch_tb_top
  import rsch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BEEP_T = 5; // Keeps the run brief
  logic core_clk, reset, inst_reset, cmd_valid, save_cmd, err_push, parse_done;
  logic cmd_ready, rsp_valid, tx_valid, flow_xon, save_strobe, keypad_locked, beep_on, rx_valid;
  logic [3:0] cmd_op;
  logic [15:0] cmd_arg, ques_enable, rd;
  logic signed [15:0] err_code, rsp_value;
  logic [1:0] rsp_kind, rk;
  logic [7:0] rx_char, tx_char;
  logic [2:0] baud_sel;
  logic [4:0] bus_addr, saved_addr, host_addr;
  logic rv;
  int n_mismatch = 0;
  int cmp_count  = 0;

  rsch_top #(.BEEP_CYCLES(BEEP_T)) dut (.core_clk(core_clk), .reset(reset),
    .inst_reset(inst_reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .save_cmd(save_cmd), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind),
    .rsp_value(rsp_value), .ques_enable(ques_enable), .err_push(err_push), .err_code(err_code),
    .rx_valid(rx_valid), .rx_char(rx_char), .parse_done(parse_done), .tx_valid(tx_valid),
    .tx_char(tx_char), .baud_sel(baud_sel), .flow_xon(flow_xon), .bus_addr(bus_addr),
    .saved_addr(saved_addr), .save_strobe(save_strobe), .keypad_locked(keypad_locked),
    .beep_on(beep_on));
  rsch_host_model host (.core_clk(core_clk), .tx_valid(tx_valid), .tx_char(tx_char),
    .rx_valid(rx_valid), .rx_char(rx_char));

  // Free-running clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Hold until taken, grab the reply
  task automatic cmd(input logic [3:0] op, input logic [15:0] arg);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_mismatch++;
        close_out();
      end
      @(negedge core_clk);
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_arg = ~arg;
    rv = rsp_valid;
    rk = rsp_kind;
    rd = rsp_value;
  endtask : cmd

  task automatic ask(input logic [3:0] op, input logic [15:0] exp, input string what);
    cmd(op, 16'h0000);
    chk({what, " valid"}, {15'h0000, rv}, 16'h0001);
    chk(what, rd, exp);
  endtask : ask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse

  // Send a character, count it back
  task automatic echo_chk(input logic [7:0] ch, input int back);
    int c;
    c = host.tx_cnt;
    host.send_char(ch);
    repeat (2) @(negedge core_clk);
    chk("echo count", 16'(host.tx_cnt - c), 16'(back));
    if (back == 1) chk("echo char", {8'h00, host.last_tx}, {8'h00, ch});
  endtask : echo_chk

  // Back-to-back error pushes, one per cycle
  task automatic push(input int base, input int step, input int k);
    for (int i = 0; i < k; i++) begin
      @(negedge core_clk);
      err_push = 1'b1;
      err_code = 16'(base - step * i);
    end
    @(negedge core_clk);
    err_push = 1'b0;
  endtask : push

  initial begin
    int n, c;
    {inst_reset, cmd_valid, save_cmd, err_push, parse_done} = '0;
    {cmd_op, cmd_arg, err_code} = '0;
    ques_enable = 16'ha5c3;
    reset = 1'b1;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    chk("reset baud", {13'h0000, baud_sel}, {13'h0000, BAUD_RESET});
    ask(OP_QMASK_QRY, 16'ha5c3, "mask");
    // Range ends, then one past
    for (int a = 0; a <= 30; a += 30) begin
      cmd(OP_ADDR_SET, 16'(a));
      host_addr = 5'(a); // host retargets
      ask(OP_ADDR_QRY, 16'(a), "addr");
    end
    cmd(OP_ADDR_SET, 16'h001f);
    chk("addr refused", {11'h000, bus_addr}, {11'h000, host_addr});
    chk("saved early", {11'h000, saved_addr}, {11'h000, ADDR_RESET});
    pulse(save_cmd);
    chk("save strobe", {15'h0000, save_strobe}, 16'h0001);
    chk("saved addr", {11'h000, saved_addr}, 16'h001e);
    for (int b = 0; b <= 5; b++) begin
      cmd(OP_BAUD_SET, 16'(b));
      chk("baud", {13'h0000, baud_sel}, 16'((b > 4) ? 4 : b));
    end
    ask(OP_BAUD_QRY, 16'(BAUD_19200), "baud qry");
    // Switch flow, keypad and prompt flags on, then off
    for (int v = 1; v >= 0; v--) begin
      cmd(OP_PACE_SET, 16'(v));
      chk("flow", {15'h0000, flow_xon}, 16'(v));
      ask(OP_PACE_QRY, 16'(v), "flow qry");
      cmd(OP_KEYB_SET, 16'(v));
      chk("keypad", {15'h0000, keypad_locked}, 16'(v));
      cmd(OP_PROM_SET, 16'(v));
      ask(OP_PROM_QRY, 16'(v), "prompt qry");
      c = host.tx_cnt;
      pulse(parse_done);
      repeat (3) @(negedge core_clk);
      chk("prompt count", 16'(host.tx_cnt - c), 16'(v));
      chk("prompt char", {8'h00, host.last_tx}, {8'h00, CHAR_PROMPT});
    end
    cmd(OP_ECHO_SET, 16'h0001);
    pulse(inst_reset);
    ask(OP_ECHO_QRY, 16'h0001, "echo qry");
    echo_chk(8'h41, 1);
    cmd(OP_ECHO_SET, 16'h0000);
    ask(OP_ECHO_QRY, 16'h0000, "echo off qry");
    echo_chk(8'h42, 1);
    echo_chk(CHAR_LF, 1);
    echo_chk(8'h43, 0);
    cmd(OP_BEEP, 16'h0000);
    n = 0;
    for (int i = 0; i < 50; i++) begin
      if (beep_on === 1'b1) n++;
      @(negedge core_clk);
    end
    chk("tone length", 16'(n), 16'(BEEP_T));
    ask(OP_ERR_QRY, ERR_NONE, "empty err");
    cmd(OP_ERR_ALL, 16'h0000);
    chk("empty list", rd, 16'h0000);
    chk("empty kind", {14'h0000, rk}, {14'h0000, RSP_LIST_END});
    push(-100, 100, 3);
    cmd(OP_ERR_CODE, 16'h0000);
    chk("code only", rd, 16'hff9c);
    chk("code kind", {14'h0000, rk}, {14'h0000, RSP_ERR_CODE});
    cmd(OP_ERR_ALL, 16'h0000);
    @(negedge core_clk);
    chk("pair kind", {14'h0000, rsp_kind}, {14'h0000, RSP_LIST_END});
    ask(OP_ERR_QRY, 16'hff38, "oldest");
    // Overfill: 30 kept, overflow mark last, rest dropped
    push(-1, 1, 34);
    cmd(OP_ERR_ALL, 16'h0000);
    for (int i = 0; i <= 30; i++) begin
      if (i > 0) begin
        @(negedge core_clk);
        rd = rsp_value;
        rk = rsp_kind;
      end
      chk("list word", rd, (i == 0) ? 16'hfed4 : (i == 30) ? ERR_OVERFLOW : 16'(-i));
      chk("list kind", {14'h0000, rk}, {14'h0000, (i == 30) ? RSP_LIST_END : RSP_ERR_CODE});
    end
    close_out();
  end
endmodule : rsch_tb_top

// ==== rsch_top.sv ====
// Purpose: System-level remote command handler of a programmable instrument
// Assumes: Commands decoded upstream into an opcode plus argument
// Notes:   Replies are word-wide values; text is formed downstream

// What this block does
// - mask query returns questionable enable register
// - address 0 to 30 set and queried
// - address persisted only on save command
// - baud rate selectable, query reports it
// - echo on sends every received character
// - echo off waits for line terminator
// - instrument reset leaves echo unchanged
// - echo query returns 01 or 00
// - pacing XON enables, NONE disables
// - pacing query returns 01 or 00
// - prompt sends '>' after each parse
// - prompt query returns 1 or 0
// - error queue first in first out
// - empty queue answers code 0
// - overflow keeps oldest, drops newest
// - final entry after overflow is -350
// - code query returns code only
// - all codes list, 31 max, 0 empty
// - keypad lock on disable, unlock enable
// - beep emits one short tone
module rsch_top
  import rsch_pkg::*;
#(
  parameter int BEEP_CYCLES = BEEP_CYC
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,

  // Instrument reset command (aborts the list walk only; settings kept)
  input  wire logic               inst_reset,

  // Decoded command
  input  wire logic               cmd_valid,
  input  wire logic [3:0]         cmd_op,
  input  wire logic [15:0]        cmd_arg,
  output logic                    cmd_ready,

  // Save-to-memory command
  input  wire logic               save_cmd,

  // Reply stream
  output logic                    rsp_valid,
  output logic [1:0]              rsp_kind,
  output logic signed [15:0]      rsp_value,

  // Questionable condition enable register
  input  wire logic [15:0]        ques_enable,

  // Error reports
  input  wire logic               err_push,
  input  wire logic signed [15:0] err_code,

  // Serial receive characters and parse events
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_char,
  input  wire logic               parse_done,

  // Serial transmit stream
  output logic                    tx_valid,
  output logic [7:0]              tx_char,

  // Serial configuration
  output logic [2:0]              baud_sel,
  output logic                    flow_xon,

  // Bus address and persistence
  output logic [4:0]              bus_addr,
  output logic [4:0]              saved_addr,
  output logic                    save_strobe,

  // Front panel
  output logic                    keypad_locked,
  output logic                    beep_on
);

  initial begin
    if (BEEP_CYCLES < 1) begin
      $error("rsch_top: BEEP_CYCLES must be positive");
    end
  end

  // List walk states, Gray ordered
  typedef enum logic [1:0] {
    RSCH_IDLE = 2'b00,
    RSCH_LIST = 2'b01,
    RSCH_LAST = 2'b11
  } rsch_state_t;

  // Sequencer and settings
  rsch_state_t state_q;       // Reply sequencer
  logic [4:0]  addr_q;        // Live bus address
  logic [4:0]  saved_q;       // Persisted address
  logic [2:0]  baud_q;        // Serial rate
  logic        pace_q;        // Flow control
  logic        prom_q;        // Parse marker
  logic        keyb_q;        // Keypad locked

  // List walk
  logic [4:0]  idx_q;         // List walk position
  logic [4:0]  last_q;        // Last list index

  // Save pulse and tone
  logic        save_q;        // Save pulse
  logic [$clog2(BEEP_CYCLES+1)-1:0] beep_q;  // Tone time left

  // Error queue view
  logic signed [15:0] head_code;
  logic signed [15:0] peek_code;
  logic [5:0]         err_count;
  logic               err_pop;

  // Echo path
  logic       echo_valid;
  logic [7:0] echo_char;
  logic       echo_active;

  // Command handshake
  logic take;
  assign cmd_ready = (state_q == RSCH_IDLE);
  assign take      = cmd_valid && cmd_ready;

  // Pop only on the two single-entry error queries
  // read removes entry
  assign err_pop = take && (cmd_op == OP_ERR_QRY || cmd_op == OP_ERR_CODE);

  rsch_err_fifo #(
    .DEPTH(ERR_DEPTH)
  ) u_err (
    .core_clk (core_clk),
    .reset    (reset),
    .push     (err_push),
    .push_code(err_code),
    .pop      (err_pop),
    .peek_idx (idx_q),
    .peek_code(peek_code),
    .head_code(head_code),
    .count    (err_count)
  );

  // Echo only cares for its own setting, not instrument reset
  // echo untouched by reset command
  rsch_echo u_echo (
    .core_clk   (core_clk),
    .reset      (reset),
    .set_valid  (take && cmd_op == OP_ECHO_SET),
    .set_on     (cmd_arg[0]),
    .rx_valid   (rx_valid),
    .rx_char    (rx_char),
    .echo_valid (echo_valid),
    .echo_char  (echo_char),
    .echo_active(echo_active)
  );

  // Address register; out-of-range values ignored
  // accept 0 to 30
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_q <= ADDR_RESET;
    end else if (take && cmd_op == OP_ADDR_SET && cmd_arg <= 16'(ADDR_MAX)) begin
      addr_q <= cmd_arg[4:0];
    end
  end

  // Persisted copy changes only on save
  // persist on save only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      saved_q <= ADDR_RESET;
      save_q  <= 1'b0;
    end else begin
      save_q <= save_cmd;
      if (save_cmd) begin
        saved_q <= addr_q;
      end
    end
  end

  // Serial settings; instrument reset leaves them alone too
  // rate select
  always_ff @(posedge core_clk) begin
    if (reset) begin
      baud_q <= BAUD_RESET;
      pace_q <= 1'b0;
      prom_q <= 1'b0;
    end else if (take) begin
      if (cmd_op == OP_BAUD_SET && cmd_arg[2:0] <= BAUD_19200) begin
        baud_q <= cmd_arg[2:0];
      end
      if (cmd_op == OP_PACE_SET) begin
        pace_q <= cmd_arg[0];
      end
      if (cmd_op == OP_PROM_SET) begin
        prom_q <= cmd_arg[0];
      end
    end
  end

  // Keypad lock, arg 1 means disable (lock)
  // lock and unlock
  always_ff @(posedge core_clk) begin
    if (reset) begin
      keyb_q <= 1'b0;
    end else if (take && cmd_op == OP_KEYB_SET) begin
      keyb_q <= cmd_arg[0];
    end
  end

  // One tone per command; a repeat restarts the tone
  // one short tone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      beep_q <= '0;
    end else if (take && cmd_op == OP_BEEP) begin
      beep_q <= ($clog2(BEEP_CYCLES+1))'(BEEP_CYCLES);
    end else if (beep_q != '0) begin
      beep_q <= beep_q - 1'b1;
    end
  end

  // List walk for the all-codes query
  // up to 31 codes
  always_ff @(posedge core_clk) begin
    if (reset || inst_reset) begin
      state_q <= RSCH_IDLE;
      idx_q   <= 5'h00;
      last_q  <= 5'h00;
    end else begin
      case (state_q)
        RSCH_IDLE: begin
          if (take && cmd_op == OP_ERR_ALL && err_count > 6'h01) begin
            // A pair needs no middle words
            state_q <= (err_count == 6'h02) ? RSCH_LAST : RSCH_LIST;
            idx_q   <= 5'h01;
            last_q  <= 5'(err_count - 6'h01);
          end
        end
        RSCH_LIST: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q + 5'h01 == last_q) begin
            state_q <= RSCH_LAST;
          end
        end
        RSCH_LAST: begin
          state_q <= RSCH_IDLE;
          idx_q   <= 5'h00;
        end
        default: begin
          state_q <= RSCH_IDLE;
        end
      endcase
    end
  end

  // Reply word, one per query or list element
  // mask readback
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_kind  <= RSP_VALUE;
      rsp_value <= 16'sh0000;
    end else if (state_q != RSCH_IDLE) begin
      rsp_valid <= 1'b1;
      rsp_kind  <= (state_q == RSCH_LAST) ? RSP_LIST_END : RSP_ERR_CODE;
      rsp_value <= peek_code;
    end else begin
      rsp_valid <= 1'b0;
      rsp_kind  <= RSP_VALUE;
      if (take) begin
        rsp_valid <= 1'b1;
        case (cmd_op)
          OP_QMASK_QRY: rsp_value <= ques_enable;
          OP_ADDR_QRY:  rsp_value <= 16'(addr_q);
          OP_BAUD_QRY:  rsp_value <= 16'(baud_q);
          OP_ECHO_QRY:  rsp_value <= 16'(echo_active);
          OP_PACE_QRY:  rsp_value <= 16'(pace_q);
          OP_PROM_QRY:  rsp_value <= 16'(prom_q);
          OP_ERR_QRY: begin
            rsp_kind  <= RSP_ERR_TEXT;
            rsp_value <= head_code;
          end
          OP_ERR_CODE: begin
            rsp_kind  <= RSP_ERR_CODE;
            rsp_value <= head_code;
          end
          OP_ERR_ALL: begin
            // Single or empty list ends at once
            rsp_kind  <= (err_count > 6'h01) ? RSP_ERR_CODE : RSP_LIST_END;
            rsp_value <= head_code;
          end
          default: begin
            // Set commands give no reply
            rsp_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // Transmit: echo first, prompt when free
  // '>' after parse
  // Limitation: a prompt colliding with an echo waits for the first cycle with no echo
  logic prompt_pend_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_valid      <= 1'b0;
      tx_char       <= 8'h00;
      prompt_pend_q <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      if (echo_valid) begin
        tx_valid      <= 1'b1;
        tx_char       <= echo_char;
        prompt_pend_q <= prompt_pend_q || (parse_done && prom_q);
      end else if (prompt_pend_q || (parse_done && prom_q)) begin
        tx_valid      <= 1'b1;
        tx_char       <= CHAR_PROMPT;
        prompt_pend_q <= 1'b0;
      end
    end
  end

  // Serial settings out
  assign baud_sel      = baud_q;
  assign flow_xon      = pace_q;

  // Address and save
  // host must follow the new address
  assign bus_addr      = addr_q;
  assign saved_addr    = saved_q;
  assign save_strobe   = save_q;

  // Front panel
  assign keypad_locked = keyb_q;
  assign beep_on       = (beep_q != '0);

endmodule : rsch_top

// ==== rsch_top_properties.sv ====
// Purpose: Port-level checks for the remote command handler
// Assumes: One clock, synchronous active-high reset
// Notes:   Prompt state is mirrored from taken commands
module rsch_top_checker
  import rsch_pkg::*;
#(
  parameter int BEEP_CYCLES = BEEP_CYC
) (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               reset,
  // Command side
  input wire logic               cmd_valid,
  input wire logic [3:0]         cmd_op,
  input wire logic [15:0]        cmd_arg,
  input wire logic               cmd_ready,
  input wire logic               save_cmd,
  input wire logic [15:0]        ques_enable,
  input wire logic               parse_done,
  // Replies and outputs
  input wire logic               rsp_valid,
  input wire logic signed [15:0] rsp_value,
  input wire logic               tx_valid,
  input wire logic [7:0]         tx_char,
  input wire logic [2:0]         baud_sel,
  input wire logic               flow_xon,
  input wire logic [4:0]         bus_addr,
  input wire logic [4:0]         saved_addr,
  input wire logic               save_strobe,
  input wire logic               beep_on
);
  logic take;      // Command taken this edge
  logic prompt_q;  // Mirrored prompt enable
  int   beep_len_q; // Length of current tone

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  assign take = cmd_valid && cmd_ready;

  // Mirror prompt setting, not visible at ports
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prompt_q <= 1'b0;
    end else if (take && cmd_op == OP_PROM_SET) begin
      prompt_q <= cmd_arg[0];
    end
  end

  // Tone length counter; a stuck tone shows here
  always_ff @(posedge core_clk) begin
    if (reset || !beep_on) begin
      beep_len_q <= 0;
    end else begin
      beep_len_q <= beep_len_q + 1;
    end
  end

  property p_addr_set;
    take && cmd_op == OP_ADDR_SET && cmd_arg <= 16'h001e |=> 16'(bus_addr) == $past(cmd_arg);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address not adopted");
  property p_addr_qry;
    take && cmd_op == OP_ADDR_QRY |=> rsp_valid && rsp_value == $signed({11'h000, bus_addr});
  endproperty
  a_addr_qry: assert property (p_addr_qry) else $error("address reply wrong");
  property p_save_hold;
    !save_cmd && !save_strobe |=> $stable(saved_addr);
  endproperty
  a_save_hold: assert property (p_save_hold) else $error("saved address moved");
  property p_save;
    save_cmd |=> save_strobe && saved_addr == $past(bus_addr);
  endproperty
  a_save: assert property (p_save) else $error("save not done");
  property p_baud_range;
    baud_sel <= BAUD_19200;
  endproperty
  a_baud_range: assert property (p_baud_range) else $error("baud code out of range");
  property p_pace_set;
    take && cmd_op == OP_PACE_SET && cmd_arg <= 16'h0001 |=> 16'(flow_xon) == $past(cmd_arg);
  endproperty
  a_pace_set: assert property (p_pace_set) else $error("flow control not set");
  property p_pace_qry;
    take && cmd_op == OP_PACE_QRY |=> rsp_valid && rsp_value == $signed({15'h0000, flow_xon});
  endproperty
  a_pace_qry: assert property (p_pace_qry) else $error("flow reply wrong");
  property p_qmask;
    take && cmd_op == OP_QMASK_QRY |=> rsp_valid && rsp_value == $signed($past(ques_enable));
  endproperty
  a_qmask: assert property (p_qmask) else $error("mask reply wrong");
  property p_prompt;
    parse_done && prompt_q |-> ##[1:2] (tx_valid && tx_char == CHAR_PROMPT);
  endproperty
  a_prompt: assert property (p_prompt) else $error("prompt missing");
  property p_beep;
    take && cmd_op == OP_BEEP |-> ##[1:2] beep_on;
  endproperty
  a_beep: assert property (p_beep) else $error("tone missing");
  property p_beep_len;
    beep_len_q <= BEEP_CYCLES;
  endproperty
  a_beep_len: assert property (p_beep_len) else $error("tone too long");

  c_save: cover property (save_cmd ##1 save_strobe);
  c_prompt: cover property (parse_done && prompt_q);
  c_walk: cover property (!cmd_ready [*8]);
endmodule : rsch_top_checker

bind rsch_top rsch_top_checker #(.BEEP_CYCLES(BEEP_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .save_cmd(save_cmd), .ques_enable(ques_enable),
  .parse_done(parse_done), .rsp_valid(rsp_valid), .rsp_value(rsp_value), .tx_valid(tx_valid),
  .tx_char(tx_char), .baud_sel(baud_sel), .flow_xon(flow_xon), .bus_addr(bus_addr),
  .saved_addr(saved_addr), .save_strobe(save_strobe), .beep_on(beep_on));
